// *** rtc_pkg.sv ***
// constants and types for the seconds and minutes counter
package rtc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 25_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int SEC_CYCLES    = TICK_PERIOD_S * CLK_HZ;
    localparam int UPDATE_CYCLES = 4;

    // ------------------------------------------------------------
    // register map, word indices; byte address is four times index
    // ------------------------------------------------------------
    localparam int          ADR_W   = 18;
    localparam logic [15:0] SEC_IDX = 16'hF068;
    localparam logic [15:0] MIN_IDX = 16'hF069;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int         BUSY_BIT  = 7;
    localparam int         TENS_MSB  = 6;
    localparam int         TENS_LSB  = 4;
    localparam int         ONES_MSB  = 3;
    localparam logic [2:0] TENS_MAX  = 3'h5;
    localparam logic [3:0] ONES_MAX  = 4'h9;

    typedef struct packed {
        logic [2:0] tens;
        logic [3:0] ones;
    } bcd_pair_type;

    localparam bcd_pair_type PAIR_RESET = 7'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_UPDATE,
        ST_COMMIT
    } upd_state_type;

endpackage

// *** tick_prescaler.sv ***
// one-second tick divider
`timescale 1ns/1ps
module tick_prescaler
    import rtc_pkg::*;
#(
    parameter int unsigned CYCLES = SEC_CYCLES
) (
    // clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // tick
    output logic      tick_o
);

    logic [31:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 32'h0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (cnt_r >= 32'(CYCLES - 1)) begin
                cnt_r  <= 32'h0;
                tick_o <= 1'b1;
            end else begin
                cnt_r  <= cnt_r + 32'h1;
                tick_o <= 1'b0;
            end
        end
    end

endmodule

// *** bcd_pair_counter.sv ***
// two-digit packed decimal counter 00..59
`timescale 1ns/1ps
module bcd_pair_counter
    import rtc_pkg::*;
(
    // clock and control
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   ce_i,
    // load and step
    input  wire logic   load_i,
    input  bcd_pair_type load_val_i,
    input  wire logic   inc_i,
    // state
    output bcd_pair_type value_o,
    output logic        wrap_o
);

    function automatic logic at_max(input bcd_pair_type p);
        at_max = (p.tens >= TENS_MAX) && (p.ones >= ONES_MAX);
    endfunction

    function automatic bcd_pair_type step(input bcd_pair_type p);
        bcd_pair_type n;
        n = p;
        if (at_max(p)) begin
            n = PAIR_RESET;
        end else if (p.ones >= ONES_MAX) begin
            n.ones = 4'h0;
            n.tens = 3'(p.tens + 3'h1);
        end else begin
            n.ones = 4'(p.ones + 4'h1);
        end
        step = n;
    endfunction

    // a bus write wins over a step in the same cycle
    assign wrap_o = inc_i && !load_i && at_max(value_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_o <= PAIR_RESET;
        end else if (ce_i) begin
            if (load_i) begin
                value_o <= load_val_i;
            end else if (inc_i) begin
                value_o <= step(value_o);
            end
        end
    end

endmodule

// *** rtc_sec_min.sv ***
// seconds and minutes counter with wishbone register access
`timescale 1ns/1ps
module rtc_sec_min
    import rtc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
    // clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // time base outputs
    output logic                   busy_o,
    output logic                   minute_tick_o,
    output logic                   hour_carry_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    upd_state_type state_r;
    upd_state_type state_nxt;
    logic [2:0]    upd_cnt_r;
    logic          pending_r;
    logic          busy_r;
    logic          tick_w;
    logic          commit_go;
    logic          bus_req;
    logic          bus_wr;
    logic          hit_sec;
    logic          hit_min;
    logic          sec_load;
    logic          min_load;
    logic          sec_wrap;
    logic          min_wrap;
    logic [31:0]   dat_nxt;
    bcd_pair_type  sec_val;
    bcd_pair_type  min_val;
    bcd_pair_type  wr_val;

    function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
        idx_hit = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    tick_prescaler #(
        .CYCLES (SEC_CYCLES_P)
    ) u_prescaler (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .tick_o (tick_w)
    );

    // ------------------------------------------------------------
    // update sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (tick_w || pending_r) begin
                    state_nxt = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                if (upd_cnt_r == 3'h0) begin
                    state_nxt = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_cnt_r <= 3'h0;
        end else if (ce_i) begin
            if (state_r == ST_IDLE) begin
                upd_cnt_r <= 3'(UPDATE_CYCLES - 1);
            end else if (upd_cnt_r != 3'h0) begin
                upd_cnt_r <= upd_cnt_r - 3'h1;
            end
        end
    end

    // tick landing during an update is kept, not lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_r <= 1'b0;
        end else if (ce_i) begin
            if (tick_w && state_r != ST_IDLE) begin
                pending_r <= 1'b1;
            end else if (state_r == ST_IDLE) begin
                pending_r <= 1'b0;
            end
        end
    end

    // busy covers every cycle in which an update may change the values; bus writes can change them while busy is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (ce_i) begin
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    assign busy_o    = busy_r;
    assign commit_go = (state_r == ST_COMMIT) && ce_i;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    assign bus_req  = wb_cyc_i && wb_stb_i;
    assign bus_wr   = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign hit_sec  = idx_hit(wb_adr_i, SEC_IDX);
    assign hit_min  = idx_hit(wb_adr_i, MIN_IDX);
    assign sec_load = bus_wr && hit_sec;
    assign min_load = bus_wr && hit_min;
    assign wr_val   = bcd_pair_type'(wb_dat_i[TENS_MSB:0]);

    bcd_pair_counter u_seconds (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .load_i     (sec_load),
        .load_val_i (wr_val),
        .inc_i      (state_r == ST_COMMIT),
        .value_o    (sec_val),
        .wrap_o     (sec_wrap)
    );

    bcd_pair_counter u_minutes (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .load_i     (min_load),
        .load_val_i (wr_val),
        .inc_i      (sec_wrap),
        .value_o    (min_val),
        .wrap_o     (min_wrap)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            minute_tick_o <= 1'b0;
            hour_carry_o  <= 1'b0;
        end else if (ce_i) begin
            minute_tick_o <= sec_wrap;
            hour_carry_o  <= min_wrap;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    always_comb begin
        dat_nxt = 32'h0;
        if (hit_sec) begin
            dat_nxt = {24'h0, busy_r, sec_val};
        end else if (hit_min) begin
            dat_nxt = {24'h0, busy_r, min_val};
        end else begin
            dat_nxt = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= dat_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    sequence s_sec_step;
        commit_go && !sec_load && (sec_val.ones < ONES_MAX);
    endsequence

    sequence s_sec_carry;
        commit_go && !sec_load && (sec_val.ones == ONES_MAX) && (sec_val.tens < TENS_MAX);
    endsequence

    sequence s_sec_rollover;
        commit_go && !sec_load && (sec_val.ones == ONES_MAX) && (sec_val.tens == TENS_MAX);
    endsequence

    sequence s_min_step;
        s_sec_rollover ##0 (!min_load && (min_val.ones < ONES_MAX));
    endsequence

    sequence s_min_rollover;
        s_sec_rollover ##0 (!min_load && (min_val.ones == ONES_MAX) && (min_val.tens == TENS_MAX));
    endsequence

    sequence s_min_carry;
        s_sec_rollover ##0 (!min_load && (min_val.ones == ONES_MAX) && (min_val.tens < TENS_MAX));
    endsequence

    a_busy_needs_tick: assert property (
        $rose(busy_r) |-> $past(tick_w || pending_r)
    ) else $error("busy rose without a pending tick");

    a_busy_reads_back: assert property (
        (wb_ack_o && !wb_we_i && (hit_sec || hit_min)) |-> (wb_dat_o[BUSY_BIT] == $past(busy_r))
    ) else $error("read data busy bit differs from busy state");

    a_busy_over_commit: assert property (
        (state_r == ST_COMMIT) |-> busy_r
    ) else $error("values change while busy is low");

    a_sec_tens_range: assert property (
        (commit_go && !sec_load && sec_val.tens <= TENS_MAX && sec_val.ones <= ONES_MAX)
        |=> (sec_val.tens <= TENS_MAX)
    ) else $error("seconds tens left 0..5");

    a_sec_ones_step: assert property (
        s_sec_step |=> (sec_val.ones == 4'($past(sec_val.ones) + 4'h1)) && (sec_val.tens == $past(sec_val.tens))
    ) else $error("seconds ones did not step by one");

    a_sec_ones_carry: assert property (
        s_sec_carry |=> (sec_val.ones == 4'h0) && (sec_val.tens == 3'($past(sec_val.tens) + 3'h1))
    ) else $error("seconds carry did not reach the tens digit");

    a_min_tens_range: assert property (
        (s_sec_rollover ##0 (!min_load && min_val.tens <= TENS_MAX && min_val.ones <= ONES_MAX))
        |=> (min_val.tens <= TENS_MAX)
    ) else $error("minutes tens left 0..5");

    a_min_ones_step: assert property (
        s_min_step |=> (min_val.ones == 4'($past(min_val.ones) + 4'h1))
    ) else $error("minutes ones did not step on the minute");

    a_sec_wrap_tick: assert property (
        s_sec_rollover |=> (minute_tick_o && sec_val == PAIR_RESET)
    ) else $error("seconds rollover missing tick or clear");

    a_min_wrap_carry: assert property (
        s_min_rollover |=> (hour_carry_o && min_val == PAIR_RESET)
    ) else $error("minutes rollover missing hour carry or clear");

    a_ack_one_cycle: assert property (
        wb_ack_o && ce_i |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

    a_ack_follows_req: assert property (
        (bus_req && !wb_ack_o && ce_i) |=> wb_ack_o
    ) else $error("taken request got no ack in the next cycle");

    a_min_tens_carry: assert property (
        s_min_carry |=> (min_val.ones == 4'h0) && (min_val.tens == 3'($past(min_val.tens) + 3'h1))
    ) else $error("minutes carry did not reach the tens digit");

    a_values_hold: assert property (
        (!commit_go && !sec_load && !min_load) |=> ($stable(sec_val) && $stable(min_val))
    ) else $error("time values changed outside an update or write");

    a_freeze_holds: assert property (
        !ce_i |=> ($stable(sec_val) && $stable(min_val) && $stable(busy_r) && $stable(state_r) && $stable(wb_ack_o))
    ) else $error("state moved while clock enable was low");

    a_hour_with_minute: assert property (
        hour_carry_o |-> minute_tick_o
    ) else $error("hour carry without a minute tick");

endmodule

// *** rtc_seconds_minutes_counter_bench.sv ***
// self-checking bench for the seconds and minutes counter
`timescale 1ns/1ps
module rtc_seconds_minutes_counter_bench;
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // setup
    // ------------------------------------------------------------
    localparam int unsigned      SEC_P = 20;
    localparam logic [ADR_W-1:0] A_SEC = {SEC_IDX, 2'b00};
    localparam logic [ADR_W-1:0] A_MIN = {MIN_IDX, 2'b00};
    localparam logic [ADR_W-1:0] A_BAD = 18'h00010;

    logic             clk_i    = 1'b0;
    logic             rst_i    = 1'b1;
    logic             ce_i     = 1'b1;
    logic             wb_cyc_i = 1'b0;
    logic             wb_stb_i = 1'b0;
    logic             wb_we_i  = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [3:0]       wb_sel_i = 4'h0;
    logic [31:0]      wb_dat_i = 32'h0;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    logic             busy_o;
    logic             minute_tick_o;
    logic             hour_carry_o;
    int               n_fail      = 0;
    int               check_count = 0;
    int               cycles      = 0;
    logic             tk;
    logic             hc;
    logic [31:0]      rd;

    always #20 clk_i = ~clk_i;

    rtc_sec_min #(.SEC_CYCLES_P(SEC_P)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .busy_o(busy_o), .minute_tick_o(minute_tick_o), .hour_carry_o(hour_carry_o)
    );

    // ------------------------------------------------------------
    // common tasks
    // ------------------------------------------------------------
    task final_report;
        $display("mismatches %0d comparisons %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; data taken at the edge where ack is high
    task wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [3:0] sel,
                 input logic [31:0] dat, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        check("ack arrives", 32'h1, 32'(wb_ack_o));
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task wr(input logic [ADR_W-1:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        logic [31:0] dummy;
        wb_xfer(1'b1, adr, sel, dat, dummy);
    endtask

    task rd_chk(input string what, input logic [ADR_W-1:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, adr, 4'hF, 32'h0, v);
        check(what, exp, v);
    endtask

    // waits one update, checks its length, returns the pulses after it
    task wait_update(output logic t, output logic c);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 100);
        n = 0;
        while (busy_o === 1'b1 && n < 100) begin
            n++;
            @(negedge clk_i);
        end
        check("busy length", 32'(UPDATE_CYCLES + 1), 32'(n));
        t = minute_tick_o;
        c = hour_carry_o;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd_chk("sec after reset", A_SEC, 32'h00);
        rd_chk("min after reset", A_MIN, 32'h00);
        rd_chk("unmapped read", A_BAD, 32'h00);
    endtask

    task t_step;
        wait_update(tk, hc);
        check("tick on plain step", 32'h0, 32'(tk));
        rd_chk("sec one step", A_SEC, 32'h01);
    endtask

    task t_busy_read;
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 100);
        wb_xfer(1'b0, A_SEC, 4'hF, 32'h0, rd);
        check("busy bit in read", 32'h1, 32'(rd[BUSY_BIT]));
        while (busy_o === 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        rd_chk("read repeated after busy", A_SEC, 32'h02);
    endtask

    task t_carry;
        wr(A_SEC, 4'h1, 32'h89);
        rd_chk("busy bit not writable", A_SEC, 32'h09);
        wait_update(tk, hc);
        rd_chk("ones carry to tens", A_SEC, 32'h10);
    endtask

    task t_min_roll;
        wr(A_MIN, 4'h1, 32'h09);
        wr(A_SEC, 4'h1, 32'h59);
        wait_update(tk, hc);
        check("minute tick", 32'h1, 32'(tk));
        check("hour carry idle", 32'h0, 32'(hc));
        rd_chk("sec wrap", A_SEC, 32'h00);
        rd_chk("min ones carry", A_MIN, 32'h10);
    endtask

    task t_hour;
        wait_update(tk, hc);
        check("no tick mid-minute", 32'h0, 32'(tk));
        wr(A_MIN, 4'h1, 32'h59);
        wr(A_SEC, 4'h1, 32'h59);
        wr(A_SEC, 4'hE, 32'h33);
        wait_update(tk, hc);
        check("minute tick at hour", 32'h1, 32'(tk));
        check("hour carry", 32'h1, 32'(hc));
        rd_chk("min wrap", A_MIN, 32'h00);
        rd_chk("sec wrap, masked write", A_SEC, 32'h00);
    endtask

    // clock enable low must stop the time base and the counters
    task t_freeze;
        wait_update(tk, hc);
        wr(A_SEC, 4'h1, 32'h25);
        ce_i <= 1'b0;
        repeat (3 * SEC_P) @(posedge clk_i);
        check("busy frozen low", 32'h0, 32'(busy_o));
        ce_i <= 1'b1;
        rd_chk("seconds frozen", A_SEC, 32'h25);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_step();
        t_busy_read();
        t_carry();
        t_min_roll();
        t_hour();
        t_freeze();
        final_report();
    end
endmodule
